// ==== core/stsio_pkg.sv ====
// shared constants for the status and i/o control register block
package stsio_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] ADDR_INT_STATUS = 8'h00;   // sticky event bits
    localparam logic [7:0] ADDR_INT_MASK   = 8'h04;   // interrupt enables
    localparam logic [7:0] ADDR_STATUS     = 8'hD0;   // processor_status_flags
    localparam logic [7:0] ADDR_IO_CONTROL = 8'hF8;   // io_control

    // processor_status_flags field positions
    localparam int BANK_SELECT_LOW_BIT  = 3;
    localparam int BANK_SELECT_HIGH_BIT = 4;
    localparam int USER_FLAG_ZERO_BIT   = 5;
    localparam int NIBBLE_CARRY_BIT     = 6;
    localparam int MAIN_CARRY_BIT       = 7;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'hF8;  // bits 2..0 belong elsewhere

    // io_control field positions
    localparam int FLOAT_PORTS_BIT      = 0;
    localparam int PORT1_HIZ_BIT        = 1;
    localparam int PORT2_HIZ_BIT        = 2;
    localparam int PORT3_HIZ_BIT        = 3;
    localparam int PULLUP_DISCONNECT_BIT = 4;
    localparam int SERIAL_ERROR_BIT     = 5;
    localparam int TIMER_CASCADE_BIT    = 6;
    localparam logic [7:0] IO_CONTROL_WRITE_MASK = 8'h7F;  // bit 7 stays zero

    // interrupt status / mask field positions
    localparam int INT_SERIAL_ERROR_BIT = 0;
    localparam int INT_MAIN_CARRY_BIT   = 1;
    localparam logic [7:0] INT_BITS_MASK = 8'h03;

    // reset values
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [7:0] IO_CONTROL_RESET = 8'h00;
    localparam logic [7:0] INT_STATUS_RESET = 8'h00;
    localparam logic [7:0] INT_MASK_RESET   = 8'h00;

    // bus answer timing: ack one cycle after request seen
    localparam int ACK_LATENCY = 1;

endpackage

// ==== core/stsio_carry_calc.sv ====
`timescale 1ns/10ps
`default_nettype none
// adds two bytes and reports the carries out of bit 3 and bit 7
module stsio_carry_calc #(
    parameter int WIDTH = 8
) (
    // operands
    input  wire logic [WIDTH-1:0] op_a,
    input  wire logic [WIDTH-1:0] op_b,
    input  wire logic             carry_in,
    // results
    output logic      [WIDTH-1:0] sum,
    output logic                  carry_nibble,
    output logic                  carry_out
);
    logic [4:0]     low_sum;   // low nibble plus carry out of bit 3
    logic [WIDTH:0] full_sum;  // whole byte plus carry out of the top bit

    // low nibble sum yields the half carry
    assign low_sum  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
    // full sum yields the main carry
    assign full_sum = {1'b0, op_a} + {1'b0, op_b} + {{WIDTH{1'b0}}, carry_in};

    assign sum          = full_sum[WIDTH-1:0];
    assign carry_nibble = low_sum[4];
    assign carry_out    = full_sum[WIDTH];
endmodule // stsio_carry_calc
`default_nettype wire

// ==== core/stsio_regs.sv ====
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module stsio_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // alu result from an arithmetic instruction
    input  wire logic        alu_op_valid,
    input  wire logic [7:0]  alu_op_a,
    input  wire logic [7:0]  alu_op_b,
    input  wire logic        alu_carry_in,
    // register bank addressing
    input  wire logic [2:0]  ram_reg_index,
    output logic      [4:0]  ram_bank_addr,
    // power down states
    input  wire logic        power_down_state,
    input  wire logic        hard_power_down_state,
    // port control
    output logic             ports_floating,
    output logic      [3:1]  port_high_impedance,
    output logic             pullup_disconnect,
    // serial and timer hooks
    input  wire logic        serial_receive_error,
    output logic             timer_cascade_select,
    // interrupt
    output logic             irq
);
    // register state
    logic [7:0]  status_q;        // processor_status_flags
    logic [7:0]  io_control_q;    // io_control
    logic [7:0]  int_status_q;    // sticky events
    logic [7:0]  int_mask_q;      // interrupt enables
    logic        wb_ack_q;        // bus acknowledge
    logic [31:0] wb_dat_q;        // read data
    logic [4:0]  ram_bank_addr_q; // mapped register address
    logic        ports_floating_q;
    logic [3:1]  port_hiz_q;
    logic        pullup_disc_q;
    logic        cascade_q;
    logic        irq_q;

    // decoded access
    logic        bus_req;         // a new request waits for its answer
    logic        wr_en;           // write takes effect this edge
    logic        wr_status;
    logic        wr_io_control;
    logic        wr_int_status;
    logic        wr_int_mask;
    logic [7:0]  wr_byte;         // low byte of write data
    logic [31:0] rd_data_d;       // read mux result

    // alu carries
    logic        alu_carry_nibble;
    logic        alu_carry_out;

    // any power-down state
    logic        in_power_down;

    // carry calculation for the flags
    stsio_carry_calc #(
        .WIDTH (8)
    ) u_carry (
        .op_a         (alu_op_a),
        .op_b         (alu_op_b),
        .carry_in     (alu_carry_in),
        .sum          (),
        .carry_nibble (alu_carry_nibble),
        .carry_out    (alu_carry_out)
    );

    // request decode; ack comes one cycle after the request is seen
    assign bus_req       = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wr_en         = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_byte       = wb_dat_i[7:0];
    assign wr_status     = wr_en && (wb_adr_i == stsio_pkg::ADDR_STATUS);
    assign wr_io_control = wr_en && (wb_adr_i == stsio_pkg::ADDR_IO_CONTROL);
    assign wr_int_status = wr_en && (wb_adr_i == stsio_pkg::ADDR_INT_STATUS);
    assign wr_int_mask   = wr_en && (wb_adr_i == stsio_pkg::ADDR_INT_MASK);
    assign in_power_down = power_down_state || hard_power_down_state;

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_data_d = 32'h0000_0000;
        case (wb_adr_i)
            stsio_pkg::ADDR_STATUS:     rd_data_d[7:0] = status_q;
            stsio_pkg::ADDR_IO_CONTROL: rd_data_d[7:0] = io_control_q;
            stsio_pkg::ADDR_INT_STATUS: rd_data_d[7:0] = int_status_q;
            stsio_pkg::ADDR_INT_MASK:   rd_data_d[7:0] = int_mask_q;
            default:                    rd_data_d = 32'h0000_0000;
        endcase
    end

    // bus answer: one-cycle ack pulse, read data captured with it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= bus_req;
            if (bus_req) begin
                wb_dat_q <= rd_data_d;
            end
        end
    end

    // status flags; the alu result wins over a write to the carry bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= stsio_pkg::STATUS_RESET;
        end else begin
            if (wr_status) begin
                // bank select, user flag and carries are writable
                status_q <= (wr_byte & stsio_pkg::STATUS_WRITE_MASK);
            end
            if (alu_op_valid) begin
                // half carry set or cleared by bit 3 carry
                status_q[stsio_pkg::NIBBLE_CARRY_BIT] <= alu_carry_nibble;
                // main carry set or cleared by bit 7 carry
                status_q[stsio_pkg::MAIN_CARRY_BIT]   <= alu_carry_out;
            end
        end
    end

    // io_control; hardware setting the error flag wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_control_q <= stsio_pkg::IO_CONTROL_RESET;
        end else begin
            if (wr_io_control) begin
                io_control_q <= (wr_byte & stsio_pkg::IO_CONTROL_WRITE_MASK);
            end
            if (serial_receive_error) begin
                io_control_q[stsio_pkg::SERIAL_ERROR_BIT] <= 1'b1;
            end
        end
    end

    // bank mapping: bank bits form the upper address bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_bank_addr_q <= 5'h00;
        end else begin
            ram_bank_addr_q <= {status_q[stsio_pkg::BANK_SELECT_HIGH_BIT],
                                status_q[stsio_pkg::BANK_SELECT_LOW_BIT],
                                ram_reg_index};
        end
    end

    // port control outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ports_floating_q <= 1'b0;
            pullup_disc_q    <= 1'b0;
            cascade_q        <= 1'b0;
        end else begin
            // float only in power down with the bit set
            ports_floating_q <= in_power_down
                                && io_control_q[stsio_pkg::FLOAT_PORTS_BIT];
            pullup_disc_q    <= io_control_q[stsio_pkg::PULLUP_DISCONNECT_BIT];
            // timer chaining select
            cascade_q        <= io_control_q[stsio_pkg::TIMER_CASCADE_BIT];
        end
    end

    // per-port high impedance input select, one flop per port
    for (genvar p = 1; p <= 3; p++) begin : g_port_hiz
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                port_hiz_q[p] <= 1'b0;
            end else begin
                // port p follows its own io_control bit
                port_hiz_q[p] <= io_control_q[stsio_pkg::PORT1_HIZ_BIT + p - 1];
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_status_q <= stsio_pkg::INT_STATUS_RESET;
        end else begin
            if (wr_int_status) begin
                int_status_q <= int_status_q & ~wr_byte;
            end
            if (serial_receive_error) begin
                int_status_q[stsio_pkg::INT_SERIAL_ERROR_BIT] <= 1'b1;
            end
            if (alu_op_valid && alu_carry_out) begin
                int_status_q[stsio_pkg::INT_MAIN_CARRY_BIT] <= 1'b1;
            end
        end
    end

    // interrupt mask register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_mask_q <= stsio_pkg::INT_MASK_RESET;
        end else if (wr_int_mask) begin
            int_mask_q <= wr_byte & stsio_pkg::INT_BITS_MASK;
        end
    end

    // level interrupt, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_status_q & int_mask_q);
        end
    end

    // outputs straight from flops
    assign wb_ack_o             = wb_ack_q;
    assign wb_dat_o             = wb_dat_q;
    assign ram_bank_addr        = ram_bank_addr_q;
    assign ports_floating       = ports_floating_q;
    assign port_high_impedance  = port_hiz_q;
    assign pullup_disconnect    = pullup_disc_q;
    assign timer_cascade_select = cascade_q;
    assign irq                  = irq_q;

    // checking helpers: independent carry reference
    logic [8:0] chk_sum;   // byte sum with carry
    logic [4:0] chk_nib;   // nibble sum with carry
    assign chk_sum = {1'b0, alu_op_a} + {1'b0, alu_op_b} + {8'h00, alu_carry_in};
    assign chk_nib = {1'b0, alu_op_a[3:0]} + {1'b0, alu_op_b[3:0]} + {4'h0, alu_carry_in};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // bank address follows bank bits and index
    a_bank_map: assert property (
        !rst |=> ram_bank_addr == {$past(status_q[4:3]), $past(ram_reg_index)})
        else $error("bank address does not follow bank select");

    // user flag holds what software wrote
    a_user_flag_write: assert property (
        wr_status |=> status_q[5] == $past(wb_dat_i[5]))
        else $error("user flag did not take written value");

    // nibble carry set by a bit 3 carry
    a_nibble_carry_set: assert property (
        alu_op_valid && chk_nib[4] |=> status_q[6])
        else $error("nibble carry not set");

    // nibble carry cleared without one
    a_nibble_carry_clr: assert property (
        alu_op_valid && !chk_nib[4] |=> !status_q[6])
        else $error("nibble carry not cleared");

    // main carry set by a bit 7 carry
    a_main_carry_set: assert property (
        alu_op_valid && chk_sum[8] |=> status_q[7])
        else $error("main carry not set");

    // main carry cleared without one
    a_main_carry_clr: assert property (
        alu_op_valid && !chk_sum[8] |=> !status_q[7])
        else $error("main carry not cleared");

    // ports float in power down only when enabled
    a_ports_float: assert property (
        !rst |=> ports_floating == ($past(in_power_down) && $past(io_control_q[0])))
        else $error("port float state wrong");

    // ports keep driving with float bit clear
    a_ports_drive: assert property (
        !io_control_q[0] |=> !ports_floating)
        else $error("ports floated with float bit clear");

    // high impedance selects track their bits
    a_port_hiz: assert property (
        !rst |=> port_high_impedance == $past(io_control_q[3:1]))
        else $error("high impedance select wrong");

    // receive error flag is sticky and set wins
    a_serial_err_sticky: assert property (
        serial_receive_error |=> io_control_q[5] && int_status_q[0])
        else $error("receive error not latched");

    // cascade output follows its bit
    a_timer_cascade: assert property (
        io_control_q[6] |=> timer_cascade_select)
        else $error("timer cascade not selected");

    // ack is a single-cycle pulse
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // a taken request is answered in the next cycle
    a_ack_after_req: assert property (
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged in time");

    // receive error flag holds until software writes io_control
    a_serial_err_hold: assert property (
        io_control_q[5] && !wr_io_control |=> io_control_q[5])
        else $error("receive error flag lost without a write");

    // reserved bits never read as one
    a_reserved_bits_zero: assert property (
        !io_control_q[7] && status_q[2:0] == 3'h0)
        else $error("reserved bit set");

    // main carry out raises its sticky event bit
    a_carry_event_set: assert property (
        alu_op_valid && chk_sum[8] |=> int_status_q[1])
        else $error("carry event not latched");

    // interrupt level follows unmasked status one cycle later
    a_irq_level: assert property (
        !rst |=> irq == (|($past(int_status_q) & $past(int_mask_q))))
        else $error("interrupt level wrong");

    // pull-up disconnect output follows its bit
    a_pullup_follows: assert property (
        !rst |=> pullup_disconnect == $past(io_control_q[4]))
        else $error("pull-up disconnect output wrong");

    // main scenarios
    c_carry_both: cover property (alu_op_valid && chk_sum[8] && chk_nib[4]);
    c_float_power_down: cover property (ports_floating);
    c_error_irq: cover property (serial_receive_error ##[1:4] irq);
    c_bank_three: cover property (status_q[4:3] == 2'b11);
endmodule // stsio_regs
`default_nettype wire

// ==== verif/test_stsio_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the status and i/o control register block
module test_stsio_regs;
    // clock, reset and bus signals
    logic        clk;
    logic        rst;
    logic        wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    // alu, port and event signals
    logic        alu_op_valid, alu_carry_in;
    logic [7:0]  alu_op_a, alu_op_b;
    logic [2:0]  ram_reg_index;
    logic [4:0]  ram_bank_addr;
    logic        power_down_state, hard_power_down_state;
    logic        ports_floating, pullup_disconnect, timer_cascade_select;
    logic [3:1]  port_high_impedance;
    logic        serial_receive_error, irq;
    // result counters
    int          error_cnt = 0;
    int          n_tests   = 0;
    logic [31:0] rd;

    stsio_regs dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alu_op_valid(alu_op_valid),
        .alu_op_a(alu_op_a), .alu_op_b(alu_op_b), .alu_carry_in(alu_carry_in),
        .ram_reg_index(ram_reg_index), .ram_bank_addr(ram_bank_addr),
        .power_down_state(power_down_state), .hard_power_down_state(hard_power_down_state),
        .ports_floating(ports_floating), .port_high_impedance(port_high_impedance),
        .pullup_disconnect(pullup_disconnect), .serial_receive_error(serial_receive_error),
        .timer_cascade_select(timer_cascade_select), .irq(irq));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic wishbone cycle, waits for ack under a bound
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                            input logic [3:0] sel, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, dat};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    // write a byte with sel[0] set
    task automatic wb_write(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] q;
        wb_cycle(1'b1, adr, dat, 4'h1, q);
    endtask

    // read a register and compare it
    task automatic wb_check(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, adr, 8'h00, 4'hF, q);
        check(q, {24'h000000, exp});
    endtask

    // one arithmetic result, then the flags are read back
    task automatic alu_op(input logic [7:0] a, input logic [7:0] b, input logic ci,
                          input logic ac, input logic cy);
        @(posedge clk);
        alu_op_valid <= 1'b1;
        alu_op_a     <= a;
        alu_op_b     <= b;
        alu_carry_in <= ci;
        @(posedge clk);
        alu_op_valid <= 1'b0;
        wb_check(stsio_pkg::ADDR_STATUS, {cy, ac, 6'h20});
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, alu_op_valid, alu_carry_in} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        {alu_op_a, alu_op_b} = 16'h0000;
        ram_reg_index = 3'h5;
        {power_down_state, hard_power_down_state, serial_receive_error} = 3'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped address and a write without sel[0]
        wb_check(stsio_pkg::ADDR_STATUS, 8'h00);
        wb_check(stsio_pkg::ADDR_IO_CONTROL, 8'h00);
        wb_check(stsio_pkg::ADDR_INT_STATUS, 8'h00);
        wb_check(stsio_pkg::ADDR_INT_MASK, 8'h00);
        wb_write(8'h40, 8'hFF);
        wb_check(8'h40, 8'h00);
        wb_cycle(1'b1, stsio_pkg::ADDR_IO_CONTROL, 8'h0E, 4'h2, rd);
        wb_check(stsio_pkg::ADDR_IO_CONTROL, 8'h00);
        $display("test reset_and_map done");
        // every bank choice maps the register index, user flag both ways
        for (int b = 0; b < 4; b++) begin
            ram_reg_index <= 3'(7 - b);
            wb_write(stsio_pkg::ADDR_STATUS, {2'h0, b[0] ? 1'b0 : 1'b1, b[1:0], 3'h0});
            repeat (2) @(posedge clk);
            check({27'h0, ram_bank_addr}, {27'h0, b[1:0], 3'(7 - b)});
            wb_check(stsio_pkg::ADDR_STATUS, {2'h0, b[0] ? 1'b0 : 1'b1, b[1:0], 3'h0});
        end
        wb_write(stsio_pkg::ADDR_STATUS, 8'hFF);
        wb_check(stsio_pkg::ADDR_STATUS, 8'hF8);
        $display("test bank_select done");
        // carries out of bit 3 and bit 7, each alone, both and none
        wb_write(stsio_pkg::ADDR_STATUS, 8'h20);
        alu_op(8'h0F, 8'h01, 1'b0, 1'b1, 1'b0);
        alu_op(8'hF0, 8'h10, 1'b0, 1'b0, 1'b1);
        alu_op(8'hFF, 8'h00, 1'b1, 1'b1, 1'b1);
        alu_op(8'h01, 8'h02, 1'b0, 1'b0, 1'b0);
        wb_check(stsio_pkg::ADDR_INT_STATUS, 8'h02);
        $display("test carry_flags done");
        // port controls follow io_control, bit 7 stays zero
        wb_write(stsio_pkg::ADDR_IO_CONTROL, 8'hDF);
        repeat (2) @(posedge clk);
        wb_check(stsio_pkg::ADDR_IO_CONTROL, 8'h5F);
        check({29'h0, port_high_impedance}, {29'h0, 3'h7});
        check({31'h0, timer_cascade_select}, 32'h00000001);
        check({31'h0, pullup_disconnect}, 32'h00000001);
        check({31'h0, ports_floating}, 32'h00000000);
        // power down and hard power down with the float bit set, then clear
        power_down_state <= 1'b1;
        repeat (2) @(posedge clk);
        check({31'h0, ports_floating}, 32'h00000001);
        power_down_state      <= 1'b0;
        hard_power_down_state <= 1'b1;
        repeat (2) @(posedge clk);
        check({31'h0, ports_floating}, 32'h00000001);
        wb_write(stsio_pkg::ADDR_IO_CONTROL, 8'h04);
        repeat (2) @(posedge clk);
        check({31'h0, ports_floating}, 32'h00000000);
        check({29'h0, port_high_impedance}, {29'h0, 3'h2});
        check({31'h0, timer_cascade_select}, 32'h00000000);
        hard_power_down_state <= 1'b0;
        $display("test port_control done");
        // receive error is sticky, raises the interrupt only when unmasked
        wb_write(stsio_pkg::ADDR_INT_STATUS, 8'h03);
        @(posedge clk);
        serial_receive_error <= 1'b1;
        @(posedge clk);
        serial_receive_error <= 1'b0;
        wb_check(stsio_pkg::ADDR_IO_CONTROL, 8'h24);
        wb_check(stsio_pkg::ADDR_INT_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h00000000);
        wb_write(stsio_pkg::ADDR_INT_MASK, 8'h01);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h00000001);
        wb_write(stsio_pkg::ADDR_INT_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h00000000);
        wb_check(stsio_pkg::ADDR_IO_CONTROL, 8'h24);
        wb_write(stsio_pkg::ADDR_IO_CONTROL, 8'h04);
        wb_check(stsio_pkg::ADDR_IO_CONTROL, 8'h04);
        $display("test receive_error_irq done");
        print_verdict();
    end
endmodule // test_stsio_regs
`default_nettype wire
